// [design/izc_pkg.sv]
// Purpose: shared constants and types for impedance calibration and CA training
// Assumes: 100 MHz core clock; x16 DQ bus; 10-bit CA bus
// Notes: mode-register addresses and operands as decoded from the CA bus
package izc_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CA_W = 10;
  localparam int DQ_W = 16;
  localparam int IMP_W = 6;
  localparam int CNT_W = 20;

  // Mode-register addresses and operands
  localparam logic [7:0] MA_CAL = 8'h0A;
  localparam logic [7:0] MA_TRAIN_ENTRY = 8'h29;
  localparam logic [7:0] OP_TRAIN_ENTRY = 8'hA4;
  localparam logic [7:0] MA_TRAIN_EXIT = 8'h2A;
  localparam logic [7:0] OP_TRAIN_EXIT = 8'hA8;
  localparam logic [7:0] MA_TRAIN_MAP = 8'h30;
  localparam logic [7:0] OP_TRAIN_MAP = 8'hC0;

  // Reset values and short-calibration step
  localparam logic [IMP_W-1:0] IMP_DEFAULT = 6'h20;
  localparam logic [IMP_W-1:0] IMP_SHORT_STEP = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
  localparam logic [DQ_W-1:0] DQ_IDLE = 16'h0000;

  typedef struct packed {
    logic [7:0] ma;
    logic [7:0] op;
  } izc_cmd_type;

  typedef struct packed {
    logic [CA_W-1:0] rise;
    logic [CA_W-1:0] fall;
  } izc_ca_pair_type;

  typedef enum logic [1:0] {
    IZC_CAL_IDLE,
    IZC_CAL_RUN
  } izc_cal_state_type;

  typedef enum logic [1:0] {
    IZC_TR_OFF,
    IZC_TR_MAIN,
    IZC_TR_REMAP
  } izc_train_state_type;

  typedef enum logic [1:0] {
    IZC_KIND_INIT,
    IZC_KIND_LONG,
    IZC_KIND_SHORT
  } izc_cal_kind_type;

endpackage

// [design/izc_sync.sv]
// Purpose: three-flop synchroniser for inputs from outside the clock domain
// Assumes: async active-high reset
// Notes: first stage is seen only by the second; stage2 and stage3 go out
`timescale 1ns/1ns
`default_nettype none
module izc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] s2_o,
  output logic [W-1:0] s3_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign s2_o = s2_ff;
  assign s3_o = s3_ff;
endmodule
`default_nettype wire

// [design/izc_top.sv]
// Purpose: device-side impedance calibration and CA training
// Assumes: command clock, CKE, CS_n, CA and the ZQ strap arrive asynchronously
// Notes: CA is sampled on both edges of the oversampled command clock
// Notes on behaviour
// - each short calibration moves impedance at least 1.5 percent toward target
// - calibration reset restores default impedance, no busy period, ignored while a calibration runs
// - calibration pin circuitry switched off when calibration completes
// - pin tied to command-bus supply means calibration commands are ignored
// - training entry is register 29H with operand A4H, same on both edges
// - training exit is register 2AH with operand A8H, same on both edges
// - mapping change is register 30H with operand C0H, same on both edges
// - entry and exit decode reliably before any CA timing adjustment
// - first phase echoes eight CA pins, rise on even DQ, fall on odd
// - after remap CA4 goes to DQ0/DQ1 and CA9 to DQ8/DQ9
// - unused DQ driven to valid level; strobes stay static
// - training output follows the falling edge once all samples are in
// - output follows last chip-select assertion; entry and exit use the first
`timescale 1ns/1ns
`default_nettype none
module izc_top
  import izc_pkg::*;
#(
  parameter logic [7:0] OP_CAL_INIT = 8'hF0,
  parameter logic [7:0] OP_CAL_LONG = 8'hA0,
  parameter logic [7:0] OP_CAL_SHORT = 8'h50,
  parameter logic [7:0] OP_CAL_RESET = 8'hC0,
  parameter int INIT_CAL_NS = 1000,
  parameter int LONG_CAL_NS = 400,
  parameter int SHORT_CAL_NS = 100
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ck_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic [CA_W-1:0] ca_i,
  input wire logic zq_tied_i,
  input wire logic [IMP_W-1:0] imp_target_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_n_o,
  output logic dqs_oe_n_o,
  output logic zq_en_o,
  output logic cal_busy_o,
  output logic train_mode_o,
  output logic [IMP_W-1:0] imp_code_o
);
  // Least times round up to whole cycles
  localparam int INIT_CYC = (INIT_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_CYC = (LONG_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_CYC = (SHORT_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYN_W = CA_W + 4;
  logic [SYN_W-1:0] syn_s2;
  logic [SYN_W-1:0] syn_s3;
  logic ck_s2, ck_s3;
  logic cs_n_s;
  logic zq_tied_s;
  logic [CA_W-1:0] ca_s;
  izc_sync #(.W(SYN_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({ck_i, cke_i, cs_n_i, zq_tied_i, ca_i}),
    .s2_o(syn_s2),
    .s3_o(syn_s3)
  );
  assign ck_s2 = syn_s2[SYN_W-1];
  assign ck_s3 = syn_s3[SYN_W-1];
  assign cs_n_s = syn_s3[SYN_W-3];
  assign zq_tied_s = syn_s3[SYN_W-4];
  assign ca_s = syn_s3[CA_W-1:0];

  function automatic logic [DQ_W-1:0] map_dq(input logic remap, input izc_ca_pair_type p);
    logic [DQ_W-1:0] d;
    d = DQ_IDLE;
    if (remap) begin
      d[0] = p.rise[4];
      d[1] = p.fall[4];
      d[8] = p.rise[9];
      d[9] = p.fall[9];
    end else begin
      d = {p.fall[8], p.rise[8], p.fall[7], p.rise[7], p.fall[6], p.rise[6],
           p.fall[5], p.rise[5], p.fall[3], p.rise[3], p.fall[2], p.rise[2],
           p.fall[1], p.rise[1], p.fall[0], p.rise[0]};
    end
    return d;
  endfunction
  function automatic logic [CNT_W-1:0] cyc(input int n);
    return n[CNT_W-1:0];
  endfunction
  // Edge detection and command capture
  logic ck_lvl_ff, nxt_ck_lvl;
  logic pend_ff, nxt_pend;
  logic [CA_W-1:0] ca_r_ff, nxt_ca_r;
  logic cmd_vld;
  izc_cmd_type cmd;
  izc_ca_pair_type pair;
  logic rise_edge;
  logic fall_edge;

  always_comb begin
    nxt_ck_lvl = ck_lvl_ff;
    nxt_pend = pend_ff;
    nxt_ca_r = ca_r_ff;
    rise_edge = 1'b0;
    fall_edge = 1'b0;
    // An edge counts only once stages two and three agree
    if (ck_s2 == ck_s3 && ck_s3 != ck_lvl_ff) begin
      nxt_ck_lvl = ck_s3;
      rise_edge = ck_s3;
      fall_edge = !ck_s3;
    end
    if (rise_edge) begin
      nxt_pend = !cs_n_s;
      nxt_ca_r = ca_s;
    end else if (fall_edge) begin
      nxt_pend = 1'b0;
    end
  end
  assign cmd_vld = fall_edge && pend_ff && (ca_r_ff[3:0] == 4'h0);
  // One driver per struct: address from rise CA9..4 and fall CA1..0, operand fall CA9..2
  assign cmd = {ca_s[1:0], ca_r_ff[9:4], ca_s[9:2]};
  assign pair = {ca_r_ff, ca_s};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ck_lvl_ff <= 1'b0;
      pend_ff <= 1'b0;
      ca_r_ff <= '0;
    end else begin
      ck_lvl_ff <= nxt_ck_lvl;
      pend_ff <= nxt_pend;
      ca_r_ff <= nxt_ca_r;
    end
  end
  // CA training
  izc_train_state_type tr_ff, nxt_tr;
  logic [DQ_W-1:0] dq_ff, nxt_dq;
  logic dq_oe_n_ff, nxt_dq_oe_n;
  logic is_entry, is_exit, is_map;

  // Both edges must carry the same encoding
  assign is_entry = cmd_vld && cmd.ma == MA_TRAIN_ENTRY && cmd.op == OP_TRAIN_ENTRY
                    && ca_r_ff == ca_s;
  assign is_exit = cmd_vld && cmd.ma == MA_TRAIN_EXIT && cmd.op == OP_TRAIN_EXIT
                   && ca_r_ff == ca_s;
  assign is_map = cmd_vld && cmd.ma == MA_TRAIN_MAP && cmd.op == OP_TRAIN_MAP
                  && ca_r_ff == ca_s;

  always_comb begin
    nxt_tr = tr_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe_n = dq_oe_n_ff;
    case (tr_ff)
      IZC_TR_OFF: begin
        if (is_entry) begin
          nxt_tr = IZC_TR_MAIN;
        end
      end
      IZC_TR_MAIN, IZC_TR_REMAP: begin
        if (is_exit) begin
          nxt_tr = IZC_TR_OFF;
          nxt_dq = DQ_IDLE;
          nxt_dq_oe_n = 1'b1;
        end else if (is_map) begin
          nxt_tr = IZC_TR_REMAP;
        end else if (is_entry) begin
          nxt_tr = tr_ff;
        end else if (fall_edge && pend_ff) begin
          // Last chip-select assertion wins, output after its falling edge
          nxt_dq = map_dq(tr_ff == IZC_TR_REMAP, pair);
          nxt_dq_oe_n = 1'b0;
        end
      end
      default: begin
        nxt_tr = IZC_TR_OFF;
        nxt_dq_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tr_ff <= IZC_TR_OFF;
      dq_ff <= DQ_IDLE;
      dq_oe_n_ff <= 1'b1;
    end else begin
      tr_ff <= nxt_tr;
      dq_ff <= nxt_dq;
      dq_oe_n_ff <= nxt_dq_oe_n;
    end
  end

  // Impedance calibration
  izc_cal_state_type cal_ff, nxt_cal;
  izc_cal_kind_type kind_ff, nxt_kind;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [IMP_W-1:0] imp_ff, nxt_imp;
  logic cal_cmd;

  // Training mode reuses CA patterns, so calibration decode is off there
  assign cal_cmd = cmd_vld && cmd.ma == MA_CAL && tr_ff == IZC_TR_OFF && !zq_tied_s;

  always_comb begin
    nxt_cal = cal_ff;
    nxt_kind = kind_ff;
    nxt_cnt = cnt_ff;
    nxt_imp = imp_ff;
    case (cal_ff)
      IZC_CAL_IDLE: begin
        if (cal_cmd) begin
          if (cmd.op == OP_CAL_RESET) begin
            nxt_imp = IMP_DEFAULT;
          end else if (cmd.op == OP_CAL_INIT) begin
            nxt_cal = IZC_CAL_RUN;
            nxt_kind = IZC_KIND_INIT;
            nxt_cnt = cyc(INIT_CYC - 1);
          end else if (cmd.op == OP_CAL_LONG) begin
            nxt_cal = IZC_CAL_RUN;
            nxt_kind = IZC_KIND_LONG;
            nxt_cnt = cyc(LONG_CYC - 1);
          end else if (cmd.op == OP_CAL_SHORT) begin
            nxt_cal = IZC_CAL_RUN;
            nxt_kind = IZC_KIND_SHORT;
            nxt_cnt = cyc(SHORT_CYC - 1);
          end
        end
      end
      IZC_CAL_RUN: begin
        if (cnt_ff != CNT_ZERO) begin
          nxt_cnt = cnt_ff - 20'h00001;
        end else begin
          nxt_cal = IZC_CAL_IDLE;
          if (kind_ff != IZC_KIND_SHORT) begin
            nxt_imp = imp_target_i;
          end else if (imp_ff < imp_target_i) begin
            nxt_imp = imp_ff + IMP_SHORT_STEP;
          end else if (imp_ff > imp_target_i) begin
            nxt_imp = imp_ff - IMP_SHORT_STEP;
          end
        end
      end
      default: begin
        nxt_cal = IZC_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_ff <= IZC_CAL_IDLE;
      kind_ff <= IZC_KIND_INIT;
      cnt_ff <= CNT_ZERO;
      imp_ff <= IMP_DEFAULT;
    end else begin
      cal_ff <= nxt_cal;
      kind_ff <= nxt_kind;
      cnt_ff <= nxt_cnt;
      imp_ff <= nxt_imp;
    end
  end

  // Outputs straight from flip-flops
  logic zq_en_ff, busy_ff, train_ff, dqs_oe_n_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zq_en_ff <= 1'b0;
      busy_ff <= 1'b0;
      train_ff <= 1'b0;
      dqs_oe_n_ff <= 1'b1;
    end else begin
      zq_en_ff <= nxt_cal == IZC_CAL_RUN;
      busy_ff <= nxt_cal == IZC_CAL_RUN;
      train_ff <= nxt_tr != IZC_TR_OFF;
      dqs_oe_n_ff <= 1'b1;
    end
  end

  assign dq_o = dq_ff;
  assign dq_oe_n_o = dq_oe_n_ff;
  assign dqs_oe_n_o = dqs_oe_n_ff;
  assign zq_en_o = zq_en_ff;
  assign cal_busy_o = busy_ff;
  assign train_mode_o = train_ff;
  assign imp_code_o = imp_ff;
endmodule
`default_nettype wire

// [testbench/izc_ctrl_model.sv]
// Purpose: controller model driving the command link of the calibration block
// Assumes: one frame per command, link clock 125 ns, idle device
// Notes: link clock stands still outside frames; CA shows no stale value after release
`timescale 1ns/1ns
`default_nettype none
module izc_ctrl_model
  import izc_pkg::*;
(
  output logic ck_o,
  output logic cke_o,
  output logic cs_n_o,
  output logic [CA_W-1:0] ca_o
);
  initial begin
    ck_o = 1'b0;
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    ca_o = '0;
  end
  // Fall value changes after the rise is sampled, held well past the fall
  task automatic send(input izc_ca_pair_type p);
    ca_o = p.rise;
    cs_n_o = 1'b0;
    #10 ck_o = 1'b1;
    #50 ca_o = p.fall;
    #13 ck_o = 1'b0;
    cs_n_o = 1'b1;
    #62 ca_o = ~p.fall;
  endtask
endmodule
`default_nettype wire

// [testbench/izc_top_asserts.sv]
// Purpose: port checks for the calibration and training block
// Assumes: single clk_i domain, async reset
// Notes: busy length counted in helper logic
`timescale 1ns/1ns
`default_nettype none
module izc_top_asserts
  import izc_pkg::*;
#(
  parameter int INIT_CAL_NS = 1000,
  parameter int LONG_CAL_NS = 400,
  parameter int SHORT_CAL_NS = 100
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic zq_tied_i,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic dq_oe_n_o,
  input wire logic dqs_oe_n_o,
  input wire logic zq_en_o,
  input wire logic cal_busy_o,
  input wire logic train_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [CNT_W-1:0] busy_cnt_ff;
  logic [CNT_W-1:0] nxt_busy_cnt;
  always_comb begin
    nxt_busy_cnt = cal_busy_o ? busy_cnt_ff + 20'h00001 : CNT_ZERO;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt_ff <= CNT_ZERO;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  dqs_static_a: assert property (dqs_oe_n_o) else $error("strobe enabled");
  zq_with_busy_a: assert property (zq_en_o == cal_busy_o)
    else $error("pin circuitry differs from busy");
  tied_ignore_a: assert property (zq_tied_i && !cal_busy_o |=> !cal_busy_o)
    else $error("calibration started with pin tied");
  busy_len_a: assert property ($fell(cal_busy_o) |->
    busy_cnt_ff == INIT_CAL_NS / CLK_PERIOD_NS || busy_cnt_ff == LONG_CAL_NS / CLK_PERIOD_NS
    || busy_cnt_ff == SHORT_CAL_NS / CLK_PERIOD_NS) else $error("wrong busy length");
  cal_in_train_a: assert property ($rose(cal_busy_o) |-> !train_mode_o)
    else $error("calibration started in training");
  dq_release_a: assert property (!train_mode_o |-> dq_oe_n_o)
    else $error("DQ driven outside training");
  dq_idle_a: assert property (dq_oe_n_o |-> dq_o == DQ_IDLE) else $error("DQ not idle");
  oe_cause_a: assert property ($fell(dq_oe_n_o) |-> train_mode_o && $past(train_mode_o))
    else $error("DQ driven without training entry");
  cover property ($rose(cal_busy_o));
  cover property ($rose(train_mode_o));
  cover property ($fell(dq_oe_n_o));
endmodule
bind izc_top izc_top_asserts #(.INIT_CAL_NS(INIT_CAL_NS), .LONG_CAL_NS(LONG_CAL_NS),
  .SHORT_CAL_NS(SHORT_CAL_NS)) u_chk (.clk_i, .rst_i, .zq_tied_i, .dq_o, .dq_oe_n_o,
  .dqs_oe_n_o, .zq_en_o, .cal_busy_o, .train_mode_o);
`default_nettype wire

// [testbench/impedance_cal_and_ca_training_test.sv]
// Purpose: self-checking bench for calibration and CA training
// Assumes: shortened calibration periods 50/30/20 cycles
// Notes: one command at a time, device idle; waits always bounded
`timescale 1ns/1ns
`default_nettype none
module impedance_cal_and_ca_training_test;
  import izc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic zq_tied_i = 1'b0;
  logic [IMP_W-1:0] imp_target_i = 6'h2A;
  wire logic ck, cke, cs_n;
  wire logic [CA_W-1:0] ca;
  logic [DQ_W-1:0] dq_o;
  logic dq_oe_n_o, dqs_oe_n_o, zq_en_o, cal_busy_o, train_mode_o;
  logic [IMP_W-1:0] imp_code_o;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int busy_n = 0;
  izc_ctrl_model u_ctrl (.ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca));
  izc_top #(.INIT_CAL_NS(500), .LONG_CAL_NS(300), .SHORT_CAL_NS(200)) dut (.clk_i, .rst_i,
    .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n), .ca_i(ca), .zq_tied_i, .imp_target_i, .dq_o,
    .dq_oe_n_o, .dqs_oe_n_o, .zq_en_o, .cal_busy_o, .train_mode_o, .imp_code_o);
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    busy_n <= busy_n + (cal_busy_o === 1'b1);
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic izc_ca_pair_type mrw(input logic [7:0] ma, input logic [7:0] op);
    return '{rise: {ma[5:0], 4'h0}, fall: {op, ma[7:6]}};
  endfunction
  // First-phase echo: eight CA pins, rise on even DQ, fall on odd
  function automatic logic [DQ_W-1:0] map1(input izc_ca_pair_type p);
    int idx[8] = '{0, 1, 2, 3, 5, 6, 7, 8};
    logic [DQ_W-1:0] d;
    for (int i = 0; i < 8; i++) begin
      d[2*i] = p.rise[idx[i]];
      d[2*i+1] = p.fall[idx[i]];
    end
    return d;
  endfunction
  task automatic cmd(input izc_ca_pair_type p);
    u_ctrl.send(p);
    @(posedge clk_i);
    #1;
  endtask
  // Next command only after the full period elapsed
  task automatic run_cal(input logic [7:0] op, input logic tied, input logic [IMP_W-1:0] tgt,
                         input int n, input logic [IMP_W-1:0] exp);
    @(posedge clk_i);
    #1 zq_tied_i = tied;
    imp_target_i = tgt;
    busy_n = 0;
    cmd(mrw(MA_CAL, op));
    repeat (200) begin
      if (cal_busy_o === 1'b1) begin
        @(posedge clk_i);
        #1;
      end
    end
    check(busy_n, n);
    check(zq_en_o, 1'b0);
    check(imp_code_o, exp);
  endtask
  task automatic train();
    izc_ca_pair_type s;
    cmd(mrw(MA_TRAIN_ENTRY, OP_TRAIN_ENTRY));
    check(train_mode_o, 1'b1);
    s = '{rise: 10'h2B5, fall: 10'h14A};
    cmd(s);
    check(dq_o, map1(s));
    check(dq_oe_n_o, 1'b0);
    // Repeated entry is ignored, earlier echo stays
    cmd(mrw(MA_TRAIN_ENTRY, OP_TRAIN_ENTRY));
    check({train_mode_o, dq_o}, {1'b1, map1(s)});
    // Calibration encoding inside training is only a sample
    s = mrw(MA_CAL, 8'hA0);
    cmd(s);
    check({cal_busy_o, dq_o}, {1'b0, map1(s)});
    s = '{rise: 10'h0CA, fall: 10'h335};
    cmd(s);
    check(dq_o, map1(s));
    cmd(mrw(MA_TRAIN_MAP, OP_TRAIN_MAP));
    s = '{rise: 10'h21F, fall: 10'h1E0};
    cmd(s);
    check(dq_o, 16'h0101);
    check(dqs_oe_n_o, 1'b1);
    cmd(mrw(MA_TRAIN_EXIT, OP_TRAIN_EXIT));
    check(train_mode_o, 1'b0);
    check({dq_oe_n_o, dq_o}, {1'b1, DQ_IDLE});
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_i = 1'b0;
    check({dq_oe_n_o, dqs_oe_n_o, zq_en_o, cal_busy_o}, 4'hC);
    check(imp_code_o, IMP_DEFAULT);
    run_cal(8'hF0, 1'b0, 6'h2A, 50, 6'h2A);
    run_cal(8'hA0, 1'b0, 6'h10, 30, 6'h10);
    run_cal(8'h50, 1'b0, 6'h2A, 20, 6'h11);
    run_cal(8'hC0, 1'b0, 6'h2A, 0, IMP_DEFAULT);
    run_cal(8'hA0, 1'b1, 6'h2A, 0, IMP_DEFAULT);
    run_cal(8'h50, 1'b0, 6'h2A, 20, 6'h21);
    train();
    summarize();
  end
endmodule
`default_nettype wire
